//--- hbp_buf2.sv
`timescale 1ns/1ps
// two-entry buffer, registered storage
module hbp_buf2 #(
	parameter int WIDTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             ce,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem_reg [2];
	logic [WIDTH-1:0] mem_next [2];
	logic             rd_ptr_reg;
	logic             rd_ptr_next;
	logic             wr_ptr_reg;
	logic             wr_ptr_next;
	logic [1:0]       count_reg;
	logic [1:0]       count_next;
	logic             push;
	logic             pop;

	if (WIDTH < 1)
	begin
		$error("width must be positive");
	end

	assign in_ready  = (count_reg != hbp_pkg::BUF_DEPTH);
	assign out_valid = (count_reg != 2'h0);
	assign out_data  = mem_reg[rd_ptr_reg];

	always_comb
	begin
		push        = in_valid && in_ready;
		pop         = out_valid && out_ready;
		mem_next    = mem_reg;
		wr_ptr_next = wr_ptr_reg;
		rd_ptr_next = rd_ptr_reg;
		count_next  = count_reg;
		if (push)
		begin
			mem_next[wr_ptr_reg] = in_data;
			wr_ptr_next          = ~wr_ptr_reg;
		end
		if (pop)
			rd_ptr_next = ~rd_ptr_reg;
		if (push && !pop)
			count_next = count_reg + 2'h1;
		else if (pop && !push)
			count_next = count_reg - 2'h1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			mem_reg[0] <= '0;
			mem_reg[1] <= '0;
			rd_ptr_reg <= 1'b0;
			wr_ptr_reg <= 1'b0;
			count_reg  <= 2'h0;
		end
		else if (ce)
		begin
			mem_reg    <= mem_next;
			rd_ptr_reg <= rd_ptr_next;
			wr_ptr_reg <= wr_ptr_next;
			count_reg  <= count_next;
		end
	end
endmodule

//--- hbp_host_byte_port.sv
`timescale 1ns/1ps
module hbp_host_byte_port #(
	parameter int DATA_W = hbp_pkg::DATA_W,
	parameter int WORD_W = hbp_pkg::WORD_W
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              ce,
	input  wire logic              reg_select_addr,
	input  wire logic              byte_half_select,
	input  wire logic              port_chip_select_n,
	input  wire logic              port_read_strobe_n,
	input  wire logic              port_write_strobe_n,
	input  wire logic [DATA_W-1:0] port_data_bus_in,
	output logic      [DATA_W-1:0] port_data_bus_out,
	output logic                   port_data_bus_oe,
	output logic                   port_read_enable_out,
	output logic                   port_write_enable_out,
	input  wire logic [WORD_W-1:0] port_status_word,
	input  wire logic              tx_valid,
	output logic                   tx_ready,
	input  wire logic [WORD_W-1:0] tx_data,
	output logic                   rx_valid,
	input  wire logic              rx_ready,
	output logic      [WORD_W-1:0] rx_data
);
	typedef enum logic [1:0] {
		HBP_IDLE  = 2'b00,
		HBP_READ  = 2'b01,
		HBP_WRITE = 2'b11,
		HBP_DONE  = 2'b10
	} hbp_state_e;

	// byte lanes are cut by the fixed slices of the package
	if (DATA_W != hbp_pkg::DATA_W || WORD_W != hbp_pkg::WORD_W)
	begin
		$error("host port widths must match the byte lanes");
	end

	// two-flop synchronisers for the host pins
	localparam int PIN_CS   = 12;
	localparam int PIN_RD   = 11;
	localparam int PIN_WR   = 10;
	localparam int PIN_SEL  = 9;
	localparam int PIN_HALF = 8;
	logic [12:0] sync1_reg;
	logic [12:0] sync2_reg;
	logic [12:0] pins;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sync1_reg <= 13'h1_c00;
			sync2_reg <= 13'h1_c00;
		end
		else if (ce)
		begin
			sync1_reg <= pins;
			sync2_reg <= sync1_reg;
		end
	end
	assign pins = {port_chip_select_n, port_read_strobe_n, port_write_strobe_n,
		reg_select_addr, byte_half_select, port_data_bus_in};

	logic       cs_s;
	logic       rd_s;
	logic       wr_s;
	logic       sel_s;
	logic       half_s;
	logic [7:0] din_s;
	logic       read_req;
	logic       write_req;
	assign cs_s      = ~sync2_reg[PIN_CS];
	assign rd_s      = ~sync2_reg[PIN_RD];
	assign wr_s      = ~sync2_reg[PIN_WR];
	assign sel_s     = sync2_reg[PIN_SEL];
	assign half_s    = sync2_reg[PIN_HALF];
	assign din_s     = sync2_reg[7:0];
	assign read_req  = cs_s && rd_s && !wr_s;
	assign write_req = cs_s && wr_s && !rd_s;

	hbp_state_e  state_reg;
	hbp_state_e  state_next;
	logic [15:0] tx_word_reg;
	logic [15:0] tx_word_next;
	logic        tx_full_reg;
	logic        tx_full_next;
	logic [15:0] rx_word_reg;
	logic [15:0] rx_word_next;
	logic        rx_push;
	logic        rx_buf_ready;
	logic [7:0]  dout_reg;
	logic [7:0]  dout_next;
	logic        oe_reg;
	logic        oe_next;

	always_comb
	begin
		state_next   = state_reg;
		tx_word_next = tx_word_reg;
		tx_full_next = tx_full_reg;
		rx_word_next = rx_word_reg;
		rx_push      = 1'b0;
		dout_next    = dout_reg;
		oe_next      = 1'b0;
		tx_ready     = !tx_full_reg;
		case (state_reg)
			HBP_IDLE:
			begin
				if (read_req)
				begin
					state_next = HBP_READ;
					oe_next    = 1'b1;
					// status word is taken once, as the read starts
					if (sel_s == hbp_pkg::SEL_STATUS)
						dout_next = (half_s == hbp_pkg::SEL_HIGH_BYTE)
							? port_status_word[hbp_pkg::HI_MSB:hbp_pkg::HI_LSB]
							: port_status_word[hbp_pkg::LO_MSB:hbp_pkg::LO_LSB];
					else
						dout_next = (half_s == hbp_pkg::SEL_HIGH_BYTE)
							? tx_word_reg[hbp_pkg::HI_MSB:hbp_pkg::HI_LSB]
							: tx_word_reg[hbp_pkg::LO_MSB:hbp_pkg::LO_LSB];
				end
				else if (write_req && rx_buf_ready)
					state_next = HBP_WRITE;
			end
			HBP_READ:
			begin
				oe_next = cs_s && rd_s;
				if (!(cs_s && rd_s))
				begin
					state_next = HBP_IDLE;
					// high byte read ends a transmit word
					if (sel_s != hbp_pkg::SEL_STATUS && half_s == hbp_pkg::SEL_HIGH_BYTE)
						tx_full_next = 1'b0;
				end
			end
			HBP_WRITE:
			begin
				// latch data at the strobe's rising edge
				// the host keeps data on the bus four clocks past it
				if (!(cs_s && wr_s))
				begin
					state_next = HBP_IDLE;
					if (sel_s != hbp_pkg::SEL_STATUS)
					begin
						if (half_s == hbp_pkg::SEL_HIGH_BYTE)
						begin
							rx_word_next[hbp_pkg::HI_MSB:hbp_pkg::HI_LSB] = din_s;
							state_next = HBP_DONE;
						end
						else
							rx_word_next[hbp_pkg::LO_MSB:hbp_pkg::LO_LSB] = din_s;
					end
				end
				else
					rx_word_next[hbp_pkg::HI_MSB:hbp_pkg::HI_LSB] =
						rx_word_reg[hbp_pkg::HI_MSB:hbp_pkg::HI_LSB];
			end
			HBP_DONE:
			begin
				rx_push    = 1'b1;
				state_next = HBP_IDLE;
			end
			default:
				state_next = HBP_IDLE;
		endcase
		// load after the case so a new word beats the read-end clear
		if (tx_valid && !tx_full_reg)
		begin
			tx_word_next = tx_data;
			tx_full_next = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg   <= HBP_IDLE;
			tx_word_reg <= hbp_pkg::TX_RESET;
			tx_full_reg <= 1'b0;
			rx_word_reg <= hbp_pkg::RX_RESET;
			dout_reg    <= 8'h00;
			oe_reg      <= 1'b0;
		end
		else if (ce)
		begin
			state_reg   <= state_next;
			tx_word_reg <= tx_word_next;
			tx_full_reg <= tx_full_next;
			rx_word_reg <= rx_word_next;
			dout_reg    <= dout_next;
			oe_reg      <= oe_next;
		end
	end

	assign port_data_bus_out     = dout_reg;
	assign port_data_bus_oe      = oe_reg;
	assign port_read_enable_out  = tx_full_reg;
	// no write is taken while a word is being pushed
	assign port_write_enable_out = rx_buf_ready && (state_reg != HBP_DONE);

	hbp_buf2 #(
		.WIDTH (hbp_pkg::WORD_W)
	) u_rx_buf (
		.clk       (clk),
		.rst       (rst),
		.ce        (ce),
		.in_valid  (rx_push),
		.in_ready  (rx_buf_ready),
		.in_data   (rx_word_reg),
		.out_valid (rx_valid),
		.out_ready (rx_ready),
		.out_data  (rx_data)
	);
endmodule

//--- hbp_host_model.sv
`timescale 1ns/1ps
module hbp_host_model (
	input  wire logic       clk,
	input  wire logic [7:0] port_data_bus_out,
	input  wire logic       port_data_bus_oe,
	output logic            reg_select_addr = 0,
	output logic            byte_half_select = 0,
	output logic            port_chip_select_n = 1,
	output logic            port_read_strobe_n = 1,
	output logic            port_write_strobe_n = 1,
	output logic      [7:0] port_data_bus_in
);
	logic [7:0] drv = 8'h00;
	logic       drv_en = 0;
	logic [7:0] last = 8'h00;
	int         timeouts = 0;
	// released wire shows a changing pattern
	assign port_data_bus_in = port_data_bus_oe ? port_data_bus_out : drv_en ? drv : ~last;
	always @(posedge clk) last <= port_data_bus_in;
	task automatic access(input logic sel, half, wr, input logic [7:0] d, output logic [7:0] q);
		q = 'x;
		@(posedge clk);
		reg_select_addr <= sel;
		byte_half_select <= half;
		port_chip_select_n <= 0;
		port_read_strobe_n <= wr;
		port_write_strobe_n <= !wr;
		drv <= d;
		drv_en <= wr;
		for (int n = 0; n < 12 && (n < 5 || (!wr && q === 'x)); n++)
		begin
			@(negedge clk);
			if (port_data_bus_oe === 1'b1)
				q = port_data_bus_out;
		end
		if (!wr && q === 'x)
			timeouts++;
		@(posedge clk);
		port_read_strobe_n <= 1;
		port_write_strobe_n <= 1;
		// data and address held past strobe release
		repeat (4) @(posedge clk);
		port_chip_select_n <= 1;
		drv_en <= 0;
		repeat (4) @(posedge clk);
	endtask
endmodule

//--- hbp_monitor.sv
`timescale 1ns/1ps
module hbp_monitor (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        reg_select_addr,
	input wire logic        byte_half_select,
	input wire logic        port_chip_select_n,
	input wire logic        port_read_strobe_n,
	input wire logic [7:0]  port_data_bus_out,
	input wire logic        port_data_bus_oe,
	input wire logic [15:0] port_status_word,
	input wire logic        rx_valid
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_status_byte: assert property (port_data_bus_oe && reg_select_addr |->
		port_data_bus_out == (byte_half_select ? port_status_word[15:8] : port_status_word[7:0]))
		else $error("status byte wrong");
	a_read_drive: assert property ($fell(port_read_strobe_n) && !port_chip_select_n |->
		##[1:5] port_data_bus_oe)
		else $error("read not driven");
	a_bus_release: assert property (port_read_strobe_n [*5] |-> !port_data_bus_oe)
		else $error("bus driven after read");
	a_idle_float: assert property (port_chip_select_n [*5] |-> !port_data_bus_oe)
		else $error("bus driven while idle");
	a_rx_source: assert property ($rose(rx_valid) |-> !reg_select_addr && byte_half_select)
		else $error("word from wrong place");
	cover property (port_data_bus_oe && reg_select_addr);
	cover property (port_data_bus_oe && !reg_select_addr);
	cover property ($rose(rx_valid));
endmodule

//--- hbp_pkg.sv
package hbp_pkg;
	localparam int          DATA_W        = 8;
	localparam int          WORD_W        = 16;
	localparam logic        SEL_STATUS    = 1'b1;
	localparam logic        SEL_HIGH_BYTE = 1'b1;
	localparam int          HI_MSB        = 15;
	localparam int          HI_LSB        = 8;
	localparam int          LO_MSB        = 7;
	localparam int          LO_LSB        = 0;
	localparam logic [15:0] RX_RESET      = 16'h0000;
	localparam logic [15:0] TX_RESET      = 16'h0000;
	localparam logic [1:0]  BUF_DEPTH     = 2'h2;
endpackage

//--- host_byte_port_test.sv
`timescale 1ns/1ps
module host_byte_port_test;
	logic        clk = 0;
	logic        rst = 1;
	logic        ce = 1;
	logic [15:0] port_status_word = 16'h5ac3;
	logic        tx_valid = 0;
	logic [15:0] tx_data = 16'h0000;
	logic        rx_ready = 1;
	logic [15:0] rx_data;
	logic        rx_valid, tx_ready, port_read_enable_out, port_write_enable_out;
	logic        reg_select_addr, byte_half_select, port_data_bus_oe;
	logic        port_chip_select_n, port_read_strobe_n, port_write_strobe_n;
	logic [7:0]  port_data_bus_in, port_data_bus_out, lo, hi;
	logic [15:0] w [3] = '{16'hbe01, 16'h7f80, 16'hffff};
	int          num_errors = 0;
	int          num_checks = 0;
	hbp_host_byte_port hbp_host_byte_port_inst (.clk, .rst, .ce, .reg_select_addr,
		.byte_half_select, .port_chip_select_n, .port_read_strobe_n, .port_write_strobe_n,
		.port_data_bus_in, .port_data_bus_out, .port_data_bus_oe, .port_read_enable_out,
		.port_write_enable_out, .port_status_word, .tx_valid, .tx_ready, .tx_data,
		.rx_valid, .rx_ready, .rx_data);
	hbp_host_model hbp_host_model_inst (.clk, .port_data_bus_out, .port_data_bus_oe,
		.reg_select_addr, .byte_half_select, .port_chip_select_n, .port_read_strobe_n,
		.port_write_strobe_n, .port_data_bus_in);
	initial forever #2 clk = ~clk;
	task automatic chk(input string nm, input logic [15:0] e, g);
		num_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic give_verdict();
		num_errors += hbp_host_model_inst.timeouts;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 0;
		@(negedge clk);
		chk("oe", 0, port_data_bus_oe);
		chk("we", 1, port_write_enable_out);
		hbp_host_model_inst.access(1, 0, 0, 8'h00, lo);
		hbp_host_model_inst.access(1, 1, 0, 8'h00, hi);
		chk("status", 16'h5ac3, {hi, lo});
		hbp_host_model_inst.access(1, 1, 1, 8'h77, lo);
		@(negedge clk);
		chk("rx_valid", 0, rx_valid);
		@(posedge clk);
		tx_valid <= 1;
		tx_data <= 16'hc3a5;
		@(posedge clk);
		tx_valid <= 0;
		@(negedge clk);
		chk("re", 1, port_read_enable_out);
		chk("tx_ready", 0, tx_ready);
		hbp_host_model_inst.access(0, 0, 0, 8'h00, lo);
		hbp_host_model_inst.access(0, 1, 0, 8'h00, hi);
		chk("tx", 16'hc3a5, {hi, lo});
		@(negedge clk);
		chk("re", 0, port_read_enable_out);
		chk("tx_ready", 1, tx_ready);
		@(posedge clk);
		rx_ready <= 0;
		for (int i = 0; i < 3; i++)
		begin
			hbp_host_model_inst.access(0, 0, 1, w[i][7:0], lo);
			hbp_host_model_inst.access(0, 1, 1, w[i][15:8], lo);
		end
		@(negedge clk);
		chk("we", 0, port_write_enable_out);
		for (int i = 0; i < 2; i++)
		begin
			@(negedge clk);
			chk("rx", w[i], rx_data);
			@(posedge clk);
			rx_ready <= 1;
			@(posedge clk);
			rx_ready <= 0;
		end
		@(negedge clk);
		chk("rx_valid", 0, rx_valid);
		@(posedge clk);
		ce <= 0;
		tx_valid <= 1;
		tx_data <= 16'h0f0f;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk("re", 0, port_read_enable_out);
		@(posedge clk);
		ce <= 1;
		@(posedge clk);
		tx_valid <= 0;
		@(negedge clk);
		chk("re", 1, port_read_enable_out);
		@(posedge clk);
		rst <= 1;
		repeat (10) @(posedge clk);
		rst <= 0;
		@(negedge clk);
		chk("re", 0, port_read_enable_out);
		chk("oe", 0, port_data_bus_oe);
		chk("we", 1, port_write_enable_out);
		hbp_host_model_inst.access(1, 1, 0, 8'h00, hi);
		chk("status_hi", 16'h005a, {8'h00, hi});
		give_verdict();
	end
endmodule
bind hbp_host_byte_port hbp_monitor hbp_monitor_inst (.clk, .rst, .reg_select_addr,
	.byte_half_select, .port_chip_select_n, .port_read_strobe_n, .port_data_bus_out,
	.port_data_bus_oe, .port_status_word, .rx_valid);
